//--- hw/flash_pkg.sv
package flash_pkg;

  // ****************************************************************
  // Geometry
  // ****************************************************************
  localparam int unsigned ADDR_W          = 9;
  localparam int unsigned DATA_W          = 16;
  localparam int unsigned CLK_OUT_DIV     = 4;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned PROG_TIME_US    = 100;
  localparam int unsigned ERASE_TIME_US   = 500;
  localparam int unsigned PROG_CYC        = PROG_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ERASE_CYC       = ERASE_TIME_US * (CLK_HZ / 1_000_000);

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [ADDR_W-1:0] ADDR_RST  = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RST  = 16'hFFFF;
  localparam logic [DATA_W-1:0] ERASED    = 16'hFFFF;

  typedef struct packed {
    logic address_shift_clock;
    logic address_shift_select;
    logic addr_in;
    logic data_shift_clock;
    logic data_shift_select;
    logic data_in;
    logic program_req;
    logic erase_req;
  } serial_req_s;

  typedef struct packed {
    logic tck;
    logic tdi;
    logic tms_load;
    logic tms_shift;
    logic tms_prog;
  } jtag_req_s;

endpackage : flash_pkg

//--- hw/clock_divider.sv
module clock_divider #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input  wire logic clk_sys_i,
  input  wire logic arst_n_i,
  // Divided outputs
  output logic      clk_div_o,
  output logic      tick_o
);

  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;

  initial begin
    if (DIV < 2 || (DIV % 2) != 0) begin
      $error("clock_divider needs an even DIV of at least 2");
    end
  end

  logic [CW-1:0] cnt_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= '0;
    end else if (cnt_q == CW'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // The output is registered so it never glitches at count wrap.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_div_o <= 1'b0;
      tick_o    <= 1'b0;
    end else begin
      clk_div_o <= (cnt_q < CW'(DIV / 2));
      tick_o    <= (cnt_q == CW'(DIV - 1));
    end
  end

endmodule : clock_divider

//--- hw/user_flash_block.sv
// Summary of operation
// - Internal oscillator divided by four is driven out as a clock.
// - Exported clock rate is fixed, nothing can program it.
// - A program or erase request runs the full algorithm internally.
// - Busy stays high during program or erase, then falls.
// - Single reads and stream reads with auto-increment are offered.
// - Shift clock with select low increments the stored address.
// - Address and data travel serially one bit at a time.
// - Address register is 9 bits, data register is 16 bits.
// - The array can also be programmed and read through JTAG.
module user_flash_block #(
  parameter int unsigned PROG_CYC  = flash_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYC = flash_pkg::ERASE_CYC
) (
  // Clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   arst_n_i,
  // Serial user interface
  input  wire flash_pkg::serial_req_s req_i,
  output logic                        data_out_o,
  output logic                        busy_o,
  // JTAG access
  input  wire flash_pkg::jtag_req_s   jtag_i,
  output logic                        tdo_o,
  // Exported clock
  output logic                        divided_internal_clock_out_o,
  output logic                        div_tick_o
);

  localparam int unsigned AW = flash_pkg::ADDR_W;
  localparam int unsigned DW = flash_pkg::DATA_W;
  localparam int unsigned DEPTH = 1 << AW;
  localparam int unsigned CW = $clog2(PROG_CYC > ERASE_CYC ?
                                      PROG_CYC + 1 : ERASE_CYC + 1);

  initial begin
    if (PROG_CYC < 1 || ERASE_CYC < 1) begin
      $error("program and erase times must be at least one cycle");
    end
  end

  // ****************************************************************
  // Exported clock
  // ****************************************************************
  clock_divider #(
    .DIV       (flash_pkg::CLK_OUT_DIV)
  ) u_clk_out_div (
    .clk_sys_i (clk_sys_i),
    .arst_n_i  (arst_n_i),
    .clk_div_o (divided_internal_clock_out_o),
    .tick_o    (div_tick_o)
  );

  // ****************************************************************
  // Edge detection of the strobes
  // ****************************************************************
  typedef enum logic [1:0] {IDLE, PROG, ERASE, DONE} op_e;

  logic          aclk_q;
  logic          dclk_q;
  logic          tck_q;
  logic          aclk_rise;
  logic          dclk_rise;
  logic          tck_rise;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] jshift_q;
  logic [AW-1:0] jaddr_q;
  op_e           op_q;
  logic [CW-1:0] timer_q;
  logic          busy_int;

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aclk_q <= 1'b0;
      dclk_q <= 1'b0;
      tck_q  <= 1'b0;
    end else begin
      aclk_q <= req_i.address_shift_clock;
      dclk_q <= req_i.data_shift_clock;
      tck_q  <= jtag_i.tck;
    end
  end

  assign aclk_rise = req_i.address_shift_clock & ~aclk_q;
  assign dclk_rise = req_i.data_shift_clock & ~dclk_q;
  assign tck_rise  = jtag_i.tck & ~tck_q;
  assign busy_int  = (op_q != IDLE);

  // ****************************************************************
  // Address register
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      addr_q <= flash_pkg::ADDR_RST;
    end else if (aclk_rise && !busy_int) begin
      if (req_i.address_shift_select) begin
        addr_q <= {addr_q[AW-2:0], req_i.addr_in};
      end else begin
        addr_q <= addr_q + AW'(1);
      end
    end
  end

  // ****************************************************************
  // Data register
  // ****************************************************************
  // Select high shifts write data in MSB first; select low with a clock
  // shifts read data out. A stream read reloads after each increment.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_q <= flash_pkg::DATA_RST;
    end else if (busy_int) begin
      data_q <= data_q;
    end else if (aclk_rise && !req_i.address_shift_select) begin
      data_q <= mem[addr_q + AW'(1)];
    end else if (dclk_rise && req_i.data_shift_select) begin
      data_q <= {data_q[DW-2:0], req_i.data_in};
    end else if (dclk_rise) begin
      data_q <= {data_q[DW-2:0], 1'b0};
    end else if (aclk_rise && req_i.address_shift_select) begin
      data_q <= mem[{addr_q[AW-2:0], req_i.addr_in}];
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_out_o <= 1'b1;
    end else begin
      data_out_o <= data_q[DW-1];
    end
  end

  // ****************************************************************
  // Program and erase sequencer
  // ****************************************************************
  // A request held past DONE does not restart: the sequencer waits for
  // release, so a held request cannot trigger a second operation.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      op_q    <= IDLE;
      timer_q <= '0;
    end else begin
      case (op_q)
        IDLE: begin
          if (req_i.erase_req) begin
            op_q    <= ERASE;
            timer_q <= CW'(ERASE_CYC - 1);
          end else if (req_i.program_req) begin
            op_q    <= PROG;
            timer_q <= CW'(PROG_CYC - 1);
          end
        end
        PROG, ERASE: begin
          if (timer_q == '0) begin
            op_q <= DONE;
          end else begin
            timer_q <= timer_q - CW'(1);
          end
        end
        DONE: begin
          if (!req_i.program_req && !req_i.erase_req) begin
            op_q <= IDLE;
          end
        end
        default: begin
          op_q <= IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_o <= 1'b0;
    end else begin
      busy_o <= (op_q == PROG || op_q == ERASE) ||
                (op_q == IDLE &&
                 (req_i.program_req || req_i.erase_req));
    end
  end

  // ****************************************************************
  // Array storage
  // ****************************************************************
  // Program only clears bits, as in real flash; erase sets the whole
  // array. The array has no reset, it models nonvolatile content.
  always_ff @(posedge clk_sys_i) begin
    if (op_q == ERASE && timer_q == '0) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= flash_pkg::ERASED;
      end
    end else if (op_q == PROG && timer_q == '0) begin
      mem[addr_q] <= mem[addr_q] & data_q;
    end else if (tck_rise && jtag_i.tms_prog && !busy_int) begin
      mem[jaddr_q] <= mem[jaddr_q] & jshift_q;
    end
  end

  // ****************************************************************
  // JTAG access
  // ****************************************************************
  // Shifts address then data through one chain; load captures a word.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jshift_q <= flash_pkg::DATA_RST;
      jaddr_q  <= flash_pkg::ADDR_RST;
      tdo_o    <= 1'b0;
    end else if (tck_rise) begin
      if (jtag_i.tms_shift) begin
        jaddr_q  <= {jaddr_q[AW-2:0], jshift_q[DW-1]};
        jshift_q <= {jshift_q[DW-2:0], jtag_i.tdi};
        tdo_o    <= jshift_q[DW-1];
      end else if (jtag_i.tms_load) begin
        jshift_q <= mem[jaddr_q];
      end
    end
  end

endmodule : user_flash_block

//--- testbench/user_flash_block_sva.sv
module flash_chk #(
  parameter int unsigned PROG_CYC  = flash_pkg::PROG_CYC,
  parameter int unsigned ERASE_CYC = flash_pkg::ERASE_CYC
) (
  // Clock and reset
  input wire logic                   clk_sys_i,
  input wire logic                   arst_n_i,
  // Watched ports
  input wire flash_pkg::serial_req_s req_i,
  input wire logic                   data_out_o,
  input wire logic                   busy_o,
  input wire logic                   divided_internal_clock_out_o,
  input wire logic                   div_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        dclk;
  logic        rise;
  logic        ers_q;
  logic        asc_q;
  logic        dsc_q;
  logic [15:0] cnt_q;
  int          len;

  assign dclk = divided_internal_clock_out_o;
  assign len  = int'(ers_q ? ERASE_CYC : PROG_CYC);
  assign rise = !busy_o && (req_i.address_shift_clock && !asc_q
                || req_i.data_shift_clock && !dsc_q);

  // The busy length is judged against the kind latched at its start.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 16'h0000;
      ers_q <= 1'b0;
      asc_q <= 1'b0;
      dsc_q <= 1'b0;
    end else begin
      cnt_q <= busy_o ? cnt_q + 16'h0001 : 16'h0000;
      ers_q <= busy_o ? ers_q : req_i.erase_req;
      asc_q <= req_i.address_shift_clock;
      dsc_q <= req_i.data_shift_clock;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  a_div_high: assert property ($rose(dclk) |=> dclk ##1 !dclk [*2]
    ##1 dclk) else $error("divided clock high phase wrong");
  a_div_low: assert property ($fell(dclk) |=> !dclk ##1 dclk [*2])
    else $error("divided clock low phase wrong");
  a_tick_period: assert property (div_tick_o |=> !div_tick_o [*3]
    ##1 div_tick_o) else $error("tick period wrong");
  a_busy_start: assert property ($rose(req_i.program_req
    || req_i.erase_req) && !busy_o |=> busy_o) else $error("busy late");
  a_busy_length: assert property ($fell(busy_o) |->
    int'(cnt_q) >= len && int'(cnt_q) <= len + 1) else $error("busy len");
  a_busy_rearm: assert property ($fell(busy_o) && (req_i.program_req
    || req_i.erase_req) |=> !busy_o) else $error("op restarted");
  a_busy_freeze: assert property (busy_o && $past(busy_o)
    && $past(busy_o, 2) |-> $stable(data_out_o)) else $error("busy strobe");
  a_out_cause: assert property ($changed(data_out_o) |->
    $past(rise, 2) || $past(rise, 3)) else $error("data out uncaused");
endmodule : flash_chk

bind user_flash_block flash_chk #(
  .PROG_CYC (PROG_CYC),
  .ERASE_CYC(ERASE_CYC)
) u_chk (
  .clk_sys_i,
  .arst_n_i,
  .req_i,
  .data_out_o,
  .busy_o,
  .divided_internal_clock_out_o,
  .div_tick_o
);

//--- testbench/flash_user_model.sv
module flash_user_model (
  // Clock and status
  input  wire logic              clk_sys_i,
  input  wire logic              busy_i,
  // Requests towards the block
  output flash_pkg::serial_req_s req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Strobes idle low so that release of reset shows no false rise.
  initial req_o = '0;

  // ********
  // Serial strobe: one clock high, then low long enough for the answer
  // ********
  task automatic strobe(input logic adr, input logic sel, input logic b);
    @(negedge clk_sys_i);
    req_o.address_shift_select = sel;
    req_o.data_shift_select = sel;
    req_o.addr_in = b;
    req_o.data_in = b;
    req_o.address_shift_clock = adr;
    req_o.data_shift_clock = !adr;
    @(negedge clk_sys_i);
    req_o.address_shift_clock = 1'b0;
    req_o.data_shift_clock = 1'b0;
    req_o.addr_in = !b;
    req_o.data_in = !b;
    repeat (2) @(negedge clk_sys_i);
  endtask : strobe

  // Releasing early would not abort the operation; hold until busy falls to count its length.
  task automatic op(input logic ers, output int n);
    @(negedge clk_sys_i);
    req_o.erase_req = ers;
    req_o.program_req = !ers;
    n = 0;
    @(negedge clk_sys_i);
    while (busy_i && n < 100) begin
      n++;
      @(negedge clk_sys_i);
    end
    // One extra cycle of hold shows that a late release cannot restart.
    @(negedge clk_sys_i);
    req_o.erase_req = 1'b0;
    req_o.program_req = 1'b0;
  endtask : op
endmodule : flash_user_model

//--- testbench/tb_user_flash_block.sv
module tb_user_flash_block;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned PC = 5;
  localparam int unsigned EC = 8;

  logic                   clk = 1'b0;
  logic                   arst_n = 1'b0;
  flash_pkg::serial_req_s req;
  flash_pkg::jtag_req_s   jtag = '0;
  logic                   dout;
  logic                   tdo;
  logic                   busy;
  logic                   dclk;
  logic                   tick;
  int                     fail_count = 0;
  int                     checks = 0;

  always #5 clk = ~clk;

  flash_user_model u_user (.clk_sys_i(clk), .busy_i(busy), .req_o(req));

  user_flash_block #(.PROG_CYC(PC), .ERASE_CYC(EC)) dut (
    .clk_sys_i                   (clk),
    .arst_n_i                    (arst_n),
    .req_i                       (req),
    .data_out_o                  (dout),
    .busy_o                      (busy),
    .jtag_i                      (jtag),
    .tdo_o                       (tdo),
    .divided_internal_clock_out_o(dclk),
    .div_tick_o                  (tick)
  );

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic cmp(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp

  task automatic hang(input int k, input int lim);
    if (k >= lim) begin
      fail_count++;
      $display("Error wait limit expected below %0d seen %0d", lim, k);
      stop_test();
    end
  endtask : hang

  task automatic t_clk_out;
    logic [7:0] w;
    int         k;
    int         t;
    w = 8'hFF;
    k = 0;
    t = 0;
    while (!(w[0] === 1'b0 && dclk === 1'b1) && k < 20) begin
      w[0] = dclk;
      @(negedge clk);
      k++;
    end
    hang(k, 20);
    for (int i = 7; i >= 0; i--) begin
      w[i] = dclk;
      t += int'(tick === 1'b1);
      @(negedge clk);
    end
    cmp("divided clock", 16'h00CC, {8'h00, w});
    cmp("tick count", 16'h0002, 16'(t));
  endtask : t_clk_out

  task automatic run_op(input logic ers);
    int n;
    int l;
    l = ers ? int'(EC) : int'(PC);
    u_user.op(ers, n);
    hang(n, 100);
    cmp("busy length", 16'h0001, 16'(n >= l && n <= l + 1));
  endtask : run_op

  task automatic load(input logic [8:0] a);
    for (int i = 8; i >= 0; i--) u_user.strobe(1'b1, 1'b1, a[i]);
  endtask : load

  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    load(a);
    for (int i = 15; i >= 0; i--) u_user.strobe(1'b0, 1'b1, d[i]);
    run_op(1'b0);
  endtask : wr

  task automatic rd(input logic [15:0] e);
    logic [15:0] w;
    for (int i = 15; i >= 0; i--) begin
      w[i] = dout;
      u_user.strobe(1'b0, 1'b0, 1'b0);
    end
    cmp("read word", e, w);
  endtask : rd

  // Array contents are unknown at start, so erase before any write or read.
  task automatic t_erase;
    run_op(1'b1);
    load(9'h1FF);
    rd(16'hFFFF);
  endtask : t_erase

  // The pair straddles an 8-bit carry to expose a short increment.
  task automatic t_stream;
    wr(9'h0FF, 16'hA5C3);
    wr(9'h100, 16'h3C5A);
    load(9'h0FF);
    rd(16'hA5C3);
    u_user.strobe(1'b1, 1'b0, 1'b0);
    rd(16'h3C5A);
  endtask : t_stream

  // One test clock pulse; m holds shift, load and program in that order.
  task automatic jtck(input logic [2:0] m, input logic b);
    @(negedge clk);
    jtag = '{tck: 1'b1, tdi: b, tms_load: m[1], tms_shift: m[2],
             tms_prog: m[0]};
    @(negedge clk);
    jtag.tck = 1'b0;
  endtask : jtck

  // Address and data share one chain, so 25 shifts place both.
  task automatic jload(input logic [8:0] a, input logic [15:0] d);
    logic [24:0] v;
    v = {a, d};
    for (int i = 24; i >= 0; i--) jtck(3'b100, v[i]);
  endtask : jload

  // Writes through the test port, reads back serially, then reads the
  // serially written word back through the test port.
  task automatic t_jtag;
    logic [15:0] w;
    jload(9'h155, 16'h6E91);
    jtck(3'b001, 1'b0);
    load(9'h155);
    rd(16'h6E91);
    jload(9'h0FF, 16'h0000);
    jtck(3'b010, 1'b0);
    for (int i = 15; i >= 0; i--) begin
      jtck(3'b100, 1'b0);
      w[i] = tdo;
    end
    cmp("jtag word", 16'hA5C3, w);
  endtask : t_jtag

  initial begin
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    cmp("idle outputs", 16'h0002, {14'h0000, dout, busy});
    t_clk_out();
    t_erase();
    t_stream();
    t_jtag();
    stop_test();
  end
endmodule : tb_user_flash_block
